//--- design/atb_pkg.sv
package atb_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_CORE_A_INPUT_TWO_QUAD_OFFSET = 10'h34a;
  localparam logic [9:0] IDX_CORE_B_INPUT_ONE_PHASE0_OFFSET = 10'h34c;
  localparam logic [9:0] IDX_CORE_B_INPUT_TWO_PHASE0_OFFSET = 10'h34e;
  localparam logic [9:0] IDX_BANK_ZERO_FINE_GAIN = 10'h360;
  localparam logic [9:0] IDX_BANK_ONE_FINE_GAIN = 10'h361;
  localparam logic [9:0] IDX_BANK_FOUR_FINE_GAIN = 10'h364;
  localparam logic [9:0] IDX_BANK_FIVE_FINE_GAIN = 10'h365;
  localparam logic [9:0] IDX_CAL_CONTROL = 10'h370;
  localparam logic [9:0] IDX_TRIM_STATUS = 10'h371;

  // Field layout
  localparam int OFS_VAL_MSB = 11;
  localparam int OFS_REG_W = 16;
  localparam int GAIN_VAL_MSB = 4;
  localparam int GAIN_REG_W = 8;
  localparam int CTRL_FG_EN_BIT = 0;
  localparam int STAT_A_OFS_LSB = 0;
  localparam int STAT_A_HIT_BIT = 12;
  localparam int STAT_B_OFS_LSB = 16;
  localparam int STAT_B_HIT_BIT = 28;
  localparam int STAT_LOAD_BIT = 31;

  // Values after reset
  localparam logic [15:0] OFS_RESET = 16'h0000;
  localparam logic [7:0] GAIN_RESET = 8'h00;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  // Conversion context encodings
  localparam logic INPUT_FIRST = 1'b0;
  localparam logic INPUT_SECOND = 1'b1;
  localparam logic PHASE_ZERO = 1'b0;
  localparam logic PHASE_QUAD = 1'b1;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic awvalid;
    logic [11:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [11:0] araddr;
    logic rready;
  } atb_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } atb_axi_rsp_t;

  typedef struct packed {
    logic input_sel;
    logic phase_sel;
  } atb_conv_t;

  typedef struct packed {
    logic [15:0] ofs_a_in2_quad;
    logic [15:0] ofs_b_in1_ph0;
    logic [15:0] ofs_b_in2_ph0;
    logic [3:0][7:0] gain;
  } atb_fuse_t;

endpackage

//--- design/atb_axil.sv
`timescale 1ns/100ps
module atb_axil (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Async reset, high
  input wire atb_pkg::atb_axi_req_t axi_i, // Bus request channels
  output atb_pkg::atb_axi_rsp_t axi_o, // Bus response channels
  output logic wr_o, // Write strobe to a mapped register
  output logic [9:0] wr_idx_o, // Write register index
  output logic [31:0] wr_data_o, // Write data
  output logic [3:0] wr_strb_o, // Write byte enables
  input wire logic wr_hit_i, // Write index is mapped
  output logic [9:0] rd_idx_o, // Read register index
  input wire logic [31:0] rd_data_i, // Read data for rd_idx_o
  input wire logic rd_hit_i // Read index is mapped
);
  import atb_pkg::*;

  logic aw_full_q, w_full_q, bvalid_q, rvalid_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic do_wr, rd_take;

  // Address and data may arrive in either order; each is held until both are in
  assign do_wr = aw_full_q & w_full_q & ~bvalid_q;
  assign rd_take = axi_i.arvalid & ~rvalid_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_full_q <= 1'b0;
      awaddr_q <= 12'h000;
    end else if (axi_i.awvalid && !aw_full_q) begin
      aw_full_q <= 1'b1;
      awaddr_q <= axi_i.awaddr;
    end else if (do_wr) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      w_full_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (axi_i.wvalid && !w_full_q) begin
      w_full_q <= 1'b1;
      wdata_q <= axi_i.wdata;
      wstrb_q <= axi_i.wstrb;
    end else if (do_wr) begin
      w_full_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit_i ? RESP_OKAY : RESP_SLVERR;
    end else if (axi_i.bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Unmapped reads answer zero with an error response
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (rd_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_hit_i ? rd_data_i : 32'h0000_0000;
      rresp_q <= rd_hit_i ? RESP_OKAY : RESP_SLVERR;
    end else if (axi_i.rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign wr_o = do_wr & wr_hit_i;
  assign wr_idx_o = awaddr_q[11:2];
  assign wr_data_o = wdata_q;
  assign wr_strb_o = wstrb_q;
  assign rd_idx_o = axi_i.araddr[11:2];

  always_comb begin
    axi_o.awready = ~aw_full_q;
    axi_o.wready = ~w_full_q;
    axi_o.bvalid = bvalid_q;
    axi_o.bresp = bresp_q;
    axi_o.arready = ~rvalid_q;
    axi_o.rvalid = rvalid_q;
    axi_o.rdata = rdata_q;
    axi_o.rresp = rresp_q;
  end

endmodule

//--- design/atb_ofs_sel.sv
`timescale 1ns/100ps
module atb_ofs_sel (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Async reset, high
  input wire logic fg_en_i, // Foreground calibration enabled
  input wire logic hit_i, // Context matches the stored trim
  input wire logic [11:0] stored_i, // Stored foreground trim
  input wire logic [11:0] alt_i, // Correction from elsewhere
  output logic [11:0] ofs_o, // Applied correction, registered
  output logic from_store_o // Applied value came from stored_i
);
  logic use_store;

  // Stored foreground trim only when calibration is on and the context fits
  assign use_store = fg_en_i & hit_i;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ofs_o <= 12'h000;
      from_store_o <= 1'b0;
    end else begin
      ofs_o <= use_store ? stored_i : alt_i;
      from_store_o <= use_store;
    end
  end

endmodule

//--- design/atb_trim_bank.sv
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/100ps
module atb_trim_bank (
  input wire logic clk_i, // Clock, 125 MHz
  input wire logic rst_i, // Async reset, high
  input wire atb_pkg::atb_axi_req_t axi_i, // AXI4-Lite request
  output atb_pkg::atb_axi_rsp_t axi_o, // AXI4-Lite response
  input wire atb_pkg::atb_fuse_t fuse_i, // Fuse storage contents
  input wire logic fuse_reload_i, // Pulse: reload trims from fuse
  input wire atb_pkg::atb_conv_t conv_a_i, // Core A conversion context
  input wire atb_pkg::atb_conv_t conv_b_i, // Core B conversion context
  input wire logic [11:0] alt_ofs_a_i, // Core A correction when not held here
  input wire logic [11:0] alt_ofs_b_i, // Core B correction when not held here
  output logic [11:0] ofs_a_o, // Core A applied offset
  output logic [11:0] ofs_b_o, // Core B applied offset
  output logic [4:0] bank_zero_fine_gain_o, // Bank 0 fine gain
  output logic [4:0] bank_one_fine_gain_o, // Bank 1 fine gain
  output logic [4:0] bank_four_fine_gain_o, // Bank 4 fine gain
  output logic [4:0] bank_five_fine_gain_o, // Bank 5 fine gain
  output logic fg_en_o, // Foreground calibration enable
  output logic load_busy_o // Fuse load pending
);
  import atb_pkg::*;

  logic wr_stb;
  logic [9:0] wr_idx;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_hit;
  logic [9:0] rd_idx;
  logic [31:0] rd_data;
  logic rd_hit;

  logic [OFS_REG_W-1:0] ofs_a_q;
  logic [OFS_REG_W-1:0] ofs_b1_q;
  logic [OFS_REG_W-1:0] ofs_b2_q;
  logic [3:0][GAIN_REG_W-1:0] gain_q;
  logic [31:0] ctrl_q;
  logic load_q;

  logic a_hit, b_hit;
  logic [11:0] b_stored;
  logic a_from_store, b_from_store;
  logic [31:0] status;
  logic [2:0] wr_slot;

  function automatic logic mapped(input logic [9:0] idx);
    case (idx)
      IDX_CORE_A_INPUT_TWO_QUAD_OFFSET,
      IDX_CORE_B_INPUT_ONE_PHASE0_OFFSET,
      IDX_CORE_B_INPUT_TWO_PHASE0_OFFSET,
      IDX_BANK_ZERO_FINE_GAIN,
      IDX_BANK_ONE_FINE_GAIN,
      IDX_BANK_FOUR_FINE_GAIN,
      IDX_BANK_FIVE_FINE_GAIN,
      IDX_CAL_CONTROL,
      IDX_TRIM_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  // Byte-lane merge for the sixteen-bit offset registers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // Gain index of a bank register, or none
  function automatic logic [2:0] gain_slot(input logic [9:0] idx);
    case (idx)
      IDX_BANK_ZERO_FINE_GAIN: gain_slot = 3'h4;
      IDX_BANK_ONE_FINE_GAIN: gain_slot = 3'h5;
      IDX_BANK_FOUR_FINE_GAIN: gain_slot = 3'h6;
      IDX_BANK_FIVE_FINE_GAIN: gain_slot = 3'h7;
      default: gain_slot = 3'h0;
    endcase
  endfunction

  atb_axil u_axil (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .axi_i(axi_i),
    .axi_o(axi_o),
    .wr_o(wr_stb),
    .wr_idx_o(wr_idx),
    .wr_data_o(wr_data),
    .wr_strb_o(wr_strb),
    .wr_hit_i(wr_hit),
    .rd_idx_o(rd_idx),
    .rd_data_i(rd_data),
    .rd_hit_i(rd_hit)
  );

  // Status is read-only; a write to it is accepted and dropped
  assign wr_hit = mapped(wr_idx);
  assign rd_hit = mapped(rd_idx);
  // A function result cannot be bit-selected, so the slot is decoded once here
  assign wr_slot = gain_slot(wr_idx);

  // Reset cannot take fuse values directly, so a load is queued at release
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      load_q <= 1'b1;
    end else begin
      load_q <= fuse_reload_i;
    end
  end

  // Fuse load wins over a software write in the same cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ofs_a_q <= OFS_RESET;
    end else if (load_q) begin
      ofs_a_q <= fuse_i.ofs_a_in2_quad;
    end else if (wr_stb && wr_idx == IDX_CORE_A_INPUT_TWO_QUAD_OFFSET) begin
      ofs_a_q <= merge16(ofs_a_q, wr_data, wr_strb);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ofs_b1_q <= OFS_RESET;
    end else if (load_q) begin
      ofs_b1_q <= fuse_i.ofs_b_in1_ph0;
    end else if (wr_stb && wr_idx == IDX_CORE_B_INPUT_ONE_PHASE0_OFFSET) begin
      ofs_b1_q <= merge16(ofs_b1_q, wr_data, wr_strb);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ofs_b2_q <= OFS_RESET;
    end else if (load_q) begin
      ofs_b2_q <= fuse_i.ofs_b_in2_ph0;
    end else if (wr_stb && wr_idx == IDX_CORE_B_INPUT_TWO_PHASE0_OFFSET) begin
      ofs_b2_q <= merge16(ofs_b2_q, wr_data, wr_strb);
    end
  end

  // Reserved gain bits are stored and read back as written
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      gain_q <= {4{GAIN_RESET}};
    end else if (load_q) begin
      gain_q <= fuse_i.gain;
    end else if (wr_stb && wr_slot[2] && wr_strb[0]) begin
      gain_q[wr_slot[1:0]] <= wr_data[GAIN_REG_W-1:0];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_stb && wr_idx == IDX_CAL_CONTROL && wr_strb[0]) begin
      ctrl_q <= {31'h0000_0000, wr_data[CTRL_FG_EN_BIT]};
    end
  end

  // Read mux; bits above each register's width read zero
  always_comb begin
    rd_data = 32'h0000_0000;
    case (rd_idx)
      IDX_CORE_A_INPUT_TWO_QUAD_OFFSET: rd_data = {16'h0000, ofs_a_q};
      IDX_CORE_B_INPUT_ONE_PHASE0_OFFSET: rd_data = {16'h0000, ofs_b1_q};
      IDX_CORE_B_INPUT_TWO_PHASE0_OFFSET: rd_data = {16'h0000, ofs_b2_q};
      IDX_BANK_ZERO_FINE_GAIN: rd_data = {24'h00_0000, gain_q[0]};
      IDX_BANK_ONE_FINE_GAIN: rd_data = {24'h00_0000, gain_q[1]};
      IDX_BANK_FOUR_FINE_GAIN: rd_data = {24'h00_0000, gain_q[2]};
      IDX_BANK_FIVE_FINE_GAIN: rd_data = {24'h00_0000, gain_q[3]};
      IDX_CAL_CONTROL: rd_data = ctrl_q;
      IDX_TRIM_STATUS: rd_data = status;
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // Context decode for each core
  assign a_hit = (conv_a_i.input_sel == INPUT_SECOND) && (conv_a_i.phase_sel == PHASE_QUAD);
  assign b_hit = (conv_b_i.phase_sel == PHASE_ZERO);
  assign b_stored = (conv_b_i.input_sel == INPUT_SECOND) ? ofs_b2_q[OFS_VAL_MSB:0]
                                                       : ofs_b1_q[OFS_VAL_MSB:0];

  atb_ofs_sel u_sel_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .fg_en_i(ctrl_q[CTRL_FG_EN_BIT]),
    .hit_i(a_hit),
    .stored_i(ofs_a_q[OFS_VAL_MSB:0]),
    .alt_i(alt_ofs_a_i),
    .ofs_o(ofs_a_o),
    .from_store_o(a_from_store)
  );

  atb_ofs_sel u_sel_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .fg_en_i(ctrl_q[CTRL_FG_EN_BIT]),
    .hit_i(b_hit),
    .stored_i(b_stored),
    .alt_i(alt_ofs_b_i),
    .ofs_o(ofs_b_o),
    .from_store_o(b_from_store)
  );

  always_comb begin
    status = 32'h0000_0000;
    status[STAT_A_OFS_LSB +: 12] = ofs_a_o;
    status[STAT_A_HIT_BIT] = a_from_store;
    status[STAT_B_OFS_LSB +: 12] = ofs_b_o;
    status[STAT_B_HIT_BIT] = b_from_store;
    status[STAT_LOAD_BIT] = load_q;
  end

  // Each bank sees only its own trim
  assign bank_zero_fine_gain_o = gain_q[0][GAIN_VAL_MSB:0];
  assign bank_one_fine_gain_o = gain_q[1][GAIN_VAL_MSB:0];
  assign bank_four_fine_gain_o = gain_q[2][GAIN_VAL_MSB:0];
  assign bank_five_fine_gain_o = gain_q[3][GAIN_VAL_MSB:0];
  assign fg_en_o = ctrl_q[CTRL_FG_EN_BIT];
  assign load_busy_o = load_q;

endmodule

//--- dv/atb_trim_bank_checker.sv
`timescale 1ns/100ps
module atb_trim_bank_checker (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire atb_pkg::atb_axi_req_t axi_i, // Bus req
  input wire atb_pkg::atb_axi_rsp_t axi_o, // Bus rsp
  input wire atb_pkg::atb_fuse_t fuse_i, // Fuse
  input wire logic fuse_reload_i, // Reload
  input wire atb_pkg::atb_conv_t conv_a_i, // Ctx A
  input wire atb_pkg::atb_conv_t conv_b_i, // Ctx B
  input wire logic [11:0] alt_ofs_a_i, // Alt A
  input wire logic [11:0] alt_ofs_b_i, // Alt B
  input wire logic [11:0] ofs_a_o, // Ofs A
  input wire logic [11:0] ofs_b_o, // Ofs B
  input wire logic [4:0] bank_zero_fine_gain_o, // Gain 0
  input wire logic [4:0] bank_one_fine_gain_o, // Gain 1
  input wire logic [4:0] bank_four_fine_gain_o, // Gain 4
  input wire logic [4:0] bank_five_fine_gain_o, // Gain 5
  input wire logic fg_en_o, // Fg enable
  input wire logic load_busy_o // Loading
);
  import atb_pkg::*;
  wire ctx_a = conv_a_i.input_sel && conv_a_i.phase_sel;
  wire ctx_b = !conv_b_i.phase_sel;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A reload request is registered first, so trims move one edge later and the applied offset one after that
  sequence s_rel_a;
    fuse_reload_i ##2 (fg_en_o && ctx_a);
  endsequence
  sequence s_rel_b;
    fuse_reload_i ##2 (fg_en_o && ctx_b);
  endsequence
  // The load after reset release legitimately keeps busy high for the release edge as well
  a_load_once: assert property (load_busy_o && !$past(rst_i) |=> !load_busy_o)
    else $error("load busy held");
  a_gain_fuse: assert property (fuse_reload_i |-> ##2 {bank_five_fine_gain_o, bank_four_fine_gain_o, bank_one_fine_gain_o, bank_zero_fine_gain_o} ==
    $past({fuse_i.gain[3][4:0], fuse_i.gain[2][4:0], fuse_i.gain[1][4:0], fuse_i.gain[0][4:0]}))
    else $error("gain not reloaded");
  a_ofs_a_fuse: assert property (s_rel_a |=> ofs_a_o == $past(fuse_i.ofs_a_in2_quad[11:0], 2))
    else $error("core A stored offset wrong");
  a_ofs_b_fuse: assert property (s_rel_b |=> ofs_b_o == ($past(conv_b_i.input_sel) ?
    $past(fuse_i.ofs_b_in2_ph0[11:0], 2) : $past(fuse_i.ofs_b_in1_ph0[11:0], 2)))
    else $error("core B stored offset wrong");
  a_alt_a: assert property (!(fg_en_o && ctx_a) |=> ofs_a_o == $past(alt_ofs_a_i))
    else $error("core A alt not used");
  a_alt_b: assert property (!(fg_en_o && ctx_b) |=> ofs_b_o == $past(alt_ofs_b_i))
    else $error("core B alt not used");
  a_wr_resp: assert property (axi_i.awvalid && axi_o.awready && axi_i.wvalid && axi_o.wready
    |-> ##[1:2] axi_o.bvalid) else $error("write response late");
  a_rd_lat: assert property (axi_i.arvalid && axi_o.arready |=> axi_o.rvalid)
    else $error("read response late");
  a_ar_block: assert property (axi_o.rvalid |-> !axi_o.arready)
    else $error("read taken while busy");
  a_b_clear: assert property (axi_o.bvalid && axi_i.bready |=> !axi_o.bvalid)
    else $error("write response repeated");
endmodule

bind atb_trim_bank atb_trim_bank_checker i_atb_trim_bank_checker (.clk_i, .rst_i, .axi_i, .axi_o,
  .fuse_i, .fuse_reload_i, .conv_a_i, .conv_b_i, .alt_ofs_a_i, .alt_ofs_b_i, .ofs_a_o, .ofs_b_o,
  .bank_zero_fine_gain_o, .bank_one_fine_gain_o, .bank_four_fine_gain_o, .bank_five_fine_gain_o, .fg_en_o, .load_busy_o);

//--- dv/atb_trim_bank_tb.sv
`timescale 1ns/100ps
module atb_trim_bank_tb;
  import atb_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  atb_axi_req_t axi_i = '0;
  atb_axi_rsp_t axi_o;
  atb_fuse_t fuse_i = {16'h9123, 16'ha456, 16'hb789, 32'he5d4c3b2};
  logic fuse_reload_i = 1'b0;
  atb_conv_t conv_a_i = 2'b11;
  atb_conv_t conv_b_i = 2'b00;
  logic [11:0] alt_ofs_a_i = 12'h5a5;
  logic [11:0] alt_ofs_b_i = 12'h3c3;
  logic [11:0] ofs_a_o, ofs_b_o;
  logic [4:0] bank_zero_fine_gain_o, bank_one_fine_gain_o, bank_four_fine_gain_o, bank_five_fine_gain_o;
  logic fg_en_o, load_busy_o;
  int n_fail = 0;
  int checks = 0;
  logic [31:0] rv, m;
  logic [1:0] rr;
  localparam logic [9:0] IDX [7] = '{IDX_CORE_A_INPUT_TWO_QUAD_OFFSET, IDX_CORE_B_INPUT_ONE_PHASE0_OFFSET,
    IDX_CORE_B_INPUT_TWO_PHASE0_OFFSET, IDX_BANK_ZERO_FINE_GAIN, IDX_BANK_ONE_FINE_GAIN,
    IDX_BANK_FOUR_FINE_GAIN, IDX_BANK_FIVE_FINE_GAIN};
  localparam logic [15:0] FZ [7] = '{16'h9123, 16'ha456, 16'hb789, 16'h00b2, 16'h00c3, 16'h00d4, 16'h00e5};
  localparam logic [19:0] GE = {FZ[6][4:0], FZ[5][4:0], FZ[4][4:0], FZ[3][4:0]};
  wire [19:0] gs = {bank_five_fine_gain_o, bank_four_fine_gain_o, bank_one_fine_gain_o, bank_zero_fine_gain_o};

  atb_trim_bank i_atb_trim_bank (.clk_i, .rst_i, .axi_i, .axi_o, .fuse_i, .fuse_reload_i, .conv_a_i,
    .conv_b_i, .alt_ofs_a_i, .alt_ofs_b_i, .ofs_a_o, .ofs_b_o, .bank_zero_fine_gain_o, .bank_one_fine_gain_o, .bank_four_fine_gain_o,
    .bank_five_fine_gain_o, .fg_en_o, .load_busy_o);

  always #4 clk_i = ~clk_i;

  task automatic report_and_stop;
    if (n_fail == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic hang(input int n);
    if (n >= 40) begin
      n_fail++;
      report_and_stop;
    end
  endtask

  // Handshakes are judged at the falling edge, where nothing can still be moving
  task automatic wr(input logic [9:0] ix, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    int n;
    logic ta, tw, tb;
    @(posedge clk_i);
    axi_i.awaddr <= {ix, 2'b00};
    axi_i.wdata <= d;
    axi_i.wstrb <= s;
    axi_i.awvalid <= 1'b1;
    axi_i.wvalid <= 1'b1;
    axi_i.bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge clk_i);
      ta = axi_i.awvalid && axi_o.awready;
      tw = axi_i.wvalid && axi_o.wready;
      tb = axi_o.bvalid;
      rr = axi_o.bresp;
      @(posedge clk_i);
      if (ta) axi_i.awvalid <= 1'b0;
      if (tw) axi_i.wvalid <= 1'b0;
      if (tb) break;
    end
    axi_i.bready <= 1'b0;
    hang(n);
    chk("bresp", er, rr);
  endtask

  task automatic rd(input logic [9:0] ix, input logic [1:0] er);
    int n;
    logic ta, tr;
    @(posedge clk_i);
    axi_i.araddr <= {ix, 2'b00};
    axi_i.arvalid <= 1'b1;
    axi_i.rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge clk_i);
      ta = axi_i.arvalid && axi_o.arready;
      tr = axi_o.rvalid;
      rv = axi_o.rdata;
      rr = axi_o.rresp;
      @(posedge clk_i);
      if (ta) axi_i.arvalid <= 1'b0;
      if (tr) break;
    end
    axi_i.rready <= 1'b0;
    hang(n);
    chk("rresp", er, rr);
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int n = 0; n < 40 && load_busy_o !== 1'b0; n++) @(negedge clk_i);
    @(negedge clk_i);
    chk("busy", 1'b0, load_busy_o);
    chk("gains", GE, gs);
    chk("fg_en", 1'b1, fg_en_o);
    for (int i = 0; i < 7; i++) begin
      m = i < 3 ? 32'h0000_ffff : 32'h0000_00ff;
      rd(IDX[i], RESP_OKAY);
      chk("fuse", FZ[i], rv);
      wr(IDX[i], ~{16'h0000, FZ[i]} & m, i < 3 ? 4'h3 : 4'h1, RESP_OKAY);
      rd(IDX[i], RESP_OKAY);
      chk("readback", ~{16'h0000, FZ[i]} & m, rv);
    end
    @(negedge clk_i);
    // Casts keep each inverted expectation at its own width instead of the compare's 32 bits
    chk("gains", 20'(~GE), gs);
    chk("ofs_a", 12'(~FZ[0][11:0]), ofs_a_o);
    chk("ofs_b", 12'(~FZ[1][11:0]), ofs_b_o);
    @(posedge clk_i);
    conv_a_i <= 2'b01;
    conv_b_i <= 2'b10;
    repeat (2) @(negedge clk_i);
    chk("ofs_b", 12'(~FZ[2][11:0]), ofs_b_o);
    chk("alt_a", alt_ofs_a_i, ofs_a_o);
    wr(IDX_CAL_CONTROL, 32'h0000_0000, 4'h1, RESP_OKAY);
    conv_a_i <= 2'b11;
    repeat (2) @(negedge clk_i);
    chk("fg_en", 1'b0, fg_en_o);
    chk("alt_a", alt_ofs_a_i, ofs_a_o);
    chk("alt_b", alt_ofs_b_i, ofs_b_o);
    rd(IDX_CAL_CONTROL, RESP_OKAY);
    chk("control", 32'h0000_0000, rv);
    wr(10'h3ff, 32'h0000_0001, 4'hf, RESP_SLVERR);
    rd(10'h3ff, RESP_SLVERR);
    chk("unmapped", 32'h0000_0000, rv);
    wr(IDX_TRIM_STATUS, 32'hffff_ffff, 4'hf, RESP_OKAY);
    wr(IDX_CAL_CONTROL, 32'h0000_0001, 4'h1, RESP_OKAY);
    fuse_reload_i <= 1'b1;
    @(posedge clk_i);
    fuse_reload_i <= 1'b0;
    repeat (3) @(negedge clk_i);
    chk("reload", GE, gs);
    chk("ofs_a", FZ[0][11:0], ofs_a_o);
    chk("ofs_b", FZ[2][11:0], ofs_b_o);
    rd(IDX[1], RESP_OKAY);
    chk("reload", FZ[1], rv);
    // Status: both cores on stored trims, fuse load finished, earlier status write ignored
    rd(IDX_TRIM_STATUS, RESP_OKAY);
    chk("status", 32'h1789_1123, rv);
    report_and_stop;
  end
endmodule
